//--- adcdc_pkg.sv
/*
 * Shared constants for the daisy-chain converter readout link.
 * Assumes both ends run on one 40 MHz system clock.
 */
package adcdc_pkg;
    // ------------------------------------------------------------
    // Word format and timing
    // ------------------------------------------------------------
    localparam int unsigned ADCDC_WORD_BITS    = 16;
    localparam int unsigned ADCDC_CLK_NS       = 25;
    // Fixed conversion time in ns, taken from the internal timebase
    localparam int unsigned ADCDC_CONV_NS      = 1400;
    localparam int unsigned ADCDC_CONV_CYC     = (ADCDC_CONV_NS + ADCDC_CLK_NS - 1) / ADCDC_CLK_NS;
    // Shift clock half period in system clocks (host divider)
    localparam int unsigned ADCDC_SCLK_HALF    = 4;
    // Quiet time after readout before strobe drops, in system clocks
    localparam int unsigned ADCDC_GAP_CYC      = 4;
    localparam logic [15:0] ADCDC_RESULT_RST   = 16'h0000;
    // Code table endpoints and midscale of the straight binary output
    localparam logic [15:0] ADCDC_CODE_FULL    = 16'hFFFF;
    localparam logic [15:0] ADCDC_CODE_MID     = 16'h8000;
    localparam logic [15:0] ADCDC_CODE_ZERO    = 16'h0000;
    localparam int unsigned ADCDC_LSB_DIV      = 65536;

    typedef enum logic [1:0] {
        ADCDC_DEV_IDLE = 2'b00,
        ADCDC_DEV_CONV = 2'b01,
        ADCDC_DEV_READ = 2'b10
    } adcdc_dev_state_t;

    typedef enum logic [2:0] {
        ADCDC_HOST_IDLE  = 3'b000,
        ADCDC_HOST_CONV  = 3'b001,
        ADCDC_HOST_SHIFT = 3'b010,
        ADCDC_HOST_GAP   = 3'b011,
        ADCDC_HOST_DONE  = 3'b100
    } adcdc_host_state_t;
endpackage

//--- adcdc_link_if.sv
/*
 * Link wires between one converter end and the host end.
 * Assumes the bench chains device ends and ties the first serial input.
 */
`timescale 1ns/1ps
`default_nettype none
interface adcdc_link_if;
    logic conversion_start_strobe;
    logic shift_clk;
    logic serial_chain_input;
    logic serial_chain_output;

    modport device (
        input  conversion_start_strobe,
        input  shift_clk,
        input  serial_chain_input,
        output serial_chain_output
    );
    modport host (
        output conversion_start_strobe,
        output shift_clk,
        input  serial_chain_output
    );
endinterface
`default_nettype wire

//--- adcdc_device.sv
/*
 * Converter end: daisy-chain mode select, fixed-time conversion,
 * busy bit option and shift-register readout on falling shift clock.
 * Assumes link pins are asynchronous to mclk and the shift clock is
 * much slower than mclk.
 */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Low chain input at strobe rise selects chain
// - No busy: drive output low, start converting
// - Shift clock low at strobe: no busy bit
// - Host keeps strobe high through readout
// - Conversion ignores shift clock activity
// - Present MSB, shift on falling edges
// - Capture chain input on each falling edge but the busy-bit one
// - First device goes low after edge sixteen
// - Forward predecessor word after own word
// - Host gives sixteen clocks per device
// - Shift clock high at strobe: busy bit
// - Chain mode even with input tied strobe
// - Sample and convert on strobe rise; code loads sample_code when conversion ends
// - Busy bit, then MSB on next edge
// - First device goes high after edge seventeen
// - Host gives one extra clock with busy
// - Power down after conversion, up at start
// - Conversion time from internal clock only
// - Result held while powered down
// - Straight binary sixteen-bit result code
// - One step is reference over 65536
// - Host should stop shift clock during conversion
module adcdc_device
    import adcdc_pkg::*;
#(
    parameter int unsigned WORD_BITS = ADCDC_WORD_BITS,
    parameter int unsigned CONV_CYC  = ADCDC_CONV_CYC
) (
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    adcdc_link_if.device              link,
    input  wire logic [WORD_BITS-1:0] sample_code,
    output logic                      sample_taken,
    output logic                      powered_up,
    output logic                      chain_mode,
    output logic                      busy_mode
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] strobe_sync_reg;
    logic [2:0] sclk_sync_reg;
    logic [2:0] sdi_sync_reg;
    logic       strobe_lvl_reg;
    logic       sclk_lvl_reg;
    logic       sdi_lvl_reg;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            strobe_sync_reg <= 3'h0;
            sclk_sync_reg   <= 3'h0;
            sdi_sync_reg    <= 3'h0;
            strobe_lvl_reg  <= 1'b0;
            sclk_lvl_reg    <= 1'b0;
            sdi_lvl_reg     <= 1'b0;
        end else begin
            strobe_sync_reg <= {strobe_sync_reg[1:0], link.conversion_start_strobe};
            sclk_sync_reg   <= {sclk_sync_reg[1:0], link.shift_clk};
            sdi_sync_reg    <= {sdi_sync_reg[1:0], link.serial_chain_input};
            if (strobe_sync_reg[1] == strobe_sync_reg[2]) begin
                strobe_lvl_reg <= strobe_sync_reg[2];
            end
            if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
                sclk_lvl_reg <= sclk_sync_reg[2];
            end
            if (sdi_sync_reg[1] == sdi_sync_reg[2]) begin
                sdi_lvl_reg <= sdi_sync_reg[2];
            end
        end
    end

    // Edge decodes on the filtered levels
    wire strobe_new  = (strobe_sync_reg[1] == strobe_sync_reg[2]) ? strobe_sync_reg[2]
                                                                   : strobe_lvl_reg;
    wire strobe_rise = strobe_new && !strobe_lvl_reg;
    wire strobe_fall = !strobe_new && strobe_lvl_reg;
    wire sclk_new    = (sclk_sync_reg[1] == sclk_sync_reg[2]) ? sclk_sync_reg[2]
                                                               : sclk_lvl_reg;
    wire sclk_fall   = !sclk_new && sclk_lvl_reg;
    wire sdi_new     = (sdi_sync_reg[1] == sdi_sync_reg[2]) ? sdi_sync_reg[2] : sdi_lvl_reg;

    // Mode is judged from the chain input level just before the strobe
    // edge, so an input wired to the strobe still reads low
    wire sel_chain   = !sdi_lvl_reg;

    // ------------------------------------------------------------
    // Conversion and readout state
    // ------------------------------------------------------------
    adcdc_dev_state_t state_reg;
    adcdc_dev_state_t state_next;
    logic [15:0]          conv_cnt_reg;
    logic [WORD_BITS-1:0] shift_reg;
    logic                 out_reg;
    logic                 chain_reg;
    logic                 busy_reg;
    logic                 busy_pend_reg;

    wire conv_done = (state_reg == ADCDC_DEV_CONV) && (conv_cnt_reg == 16'h0001);

    // Next state decode
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ADCDC_DEV_IDLE: begin
                if (strobe_rise && sel_chain) begin
                    state_next = ADCDC_DEV_CONV;
                end
            end
            ADCDC_DEV_CONV: begin
                if (conv_done) begin
                    state_next = ADCDC_DEV_READ;
                end
            end
            ADCDC_DEV_READ: begin
                if (strobe_fall) begin
                    state_next = ADCDC_DEV_IDLE;
                end
            end
            default: state_next = ADCDC_DEV_IDLE;
        endcase
    end

    // State, mode latch and internal conversion timer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg    <= ADCDC_DEV_IDLE;
            conv_cnt_reg <= 16'h0000;
            chain_reg    <= 1'b0;
            busy_reg     <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ADCDC_DEV_IDLE && strobe_rise && sel_chain) begin
                chain_reg    <= 1'b1;
                busy_reg     <= sclk_lvl_reg;
                conv_cnt_reg <= 16'(CONV_CYC);
            end else if (state_reg == ADCDC_DEV_CONV) begin
                conv_cnt_reg <= conv_cnt_reg - 16'h0001;
            end else if (state_next == ADCDC_DEV_IDLE) begin
                chain_reg    <= 1'b0;
            end
        end
    end

    // Result load, busy bit and shifting on falling shift clock
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            shift_reg     <= ADCDC_RESULT_RST;
            out_reg       <= 1'b0;
            busy_pend_reg <= 1'b0;
        end else if (state_reg == ADCDC_DEV_IDLE && strobe_rise && sel_chain) begin
            out_reg <= 1'b0;
        end else if (conv_done) begin
            shift_reg     <= sample_code;
            busy_pend_reg <= busy_reg;
            // Busy bit is high on the line, else MSB appears at once
            out_reg       <= busy_reg ? 1'b1 : sample_code[WORD_BITS-1];
        end else if (state_reg == ADCDC_DEV_READ && sclk_fall) begin
            if (busy_pend_reg) begin
                busy_pend_reg <= 1'b0;
                out_reg       <= shift_reg[WORD_BITS-1];
            end else begin
                // Take predecessor bit in at the bottom; grounded or
                // strobe-tied input shows after the own word
                shift_reg <= {shift_reg[WORD_BITS-2:0], sdi_new};
                out_reg   <= shift_reg[WORD_BITS-2];
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.serial_chain_output = out_reg;
    assign sample_taken = (state_reg == ADCDC_DEV_IDLE) && strobe_rise && sel_chain;
    assign powered_up   = (state_reg == ADCDC_DEV_CONV);
    assign chain_mode   = chain_reg;
    assign busy_mode    = busy_reg;

endmodule
`default_nettype wire

//--- adcdc_host.sv
/*
 * Host end: raises the strobe, sets shift clock level for the busy
 * option, waits out the conversion with the shift clock stopped, then
 * clocks the whole chain in and returns the collected bits.
 * Assumes the last device output is asynchronous to mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module adcdc_host
    import adcdc_pkg::*;
#(
    parameter int unsigned CHAIN_LEN = 2,
    parameter int unsigned CONV_CYC  = ADCDC_CONV_CYC + 16,
    parameter int unsigned TOT_BITS  = ADCDC_WORD_BITS * CHAIN_LEN + 1
) (
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    adcdc_link_if.host               link,
    input  wire logic                start,
    input  wire logic                want_busy,
    output logic                     ready,
    output logic                     done,
    output logic [TOT_BITS-1:0]      chain_data
);
    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    logic [2:0] sdo_sync_reg;
    logic       sdo_lvl_reg;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sdo_sync_reg <= 3'h0;
            sdo_lvl_reg  <= 1'b0;
        end else begin
            sdo_sync_reg <= {sdo_sync_reg[1:0], link.serial_chain_output};
            if (sdo_sync_reg[1] == sdo_sync_reg[2]) begin
                sdo_lvl_reg <= sdo_sync_reg[2];
            end
        end
    end

    // Level as it settles this cycle; the trip through both ends'
    // synchronisers takes seven of the eight clocks of a shift period
    wire sdo_new = (sdo_sync_reg[1] == sdo_sync_reg[2]) ? sdo_sync_reg[2] : sdo_lvl_reg;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    adcdc_host_state_t state_reg;
    logic [15:0]         cnt_reg;
    logic [7:0]          div_reg;
    logic [15:0]         edges_reg;
    logic                strobe_reg;
    logic                sclk_reg;
    logic                busy_reg;
    logic [TOT_BITS-1:0] data_reg;

    // Edge count: sixteen per device, one more with busy bit
    wire [15:0] edges_need = busy_reg ? 16'(ADCDC_WORD_BITS * CHAIN_LEN + 1)
                                      : 16'(ADCDC_WORD_BITS * CHAIN_LEN);
    wire        div_hit    = (div_reg == 8'(ADCDC_SCLK_HALF - 1));

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg  <= ADCDC_HOST_IDLE;
            cnt_reg    <= 16'h0000;
            div_reg    <= 8'h00;
            edges_reg  <= 16'h0000;
            strobe_reg <= 1'b0;
            sclk_reg   <= 1'b0;
            busy_reg   <= 1'b0;
            data_reg   <= '0;
        end else begin
            case (state_reg)
                ADCDC_HOST_IDLE: begin
                    sclk_reg <= want_busy;
                    busy_reg <= want_busy;
                    // Strobe rises a cycle later, after the level is set
                    if (start) begin
                        cnt_reg    <= 16'(CONV_CYC);
                        state_reg  <= ADCDC_HOST_CONV;
                    end
                end
                ADCDC_HOST_CONV: begin
                    // Shift clock held still while converting
                    strobe_reg <= 1'b1;
                    cnt_reg <= cnt_reg - 16'h0001;
                    if (cnt_reg == 16'h0000) begin
                        data_reg  <= '0;
                        div_reg   <= 8'h00;
                        edges_reg <= 16'h0000;
                        state_reg <= ADCDC_HOST_SHIFT;
                    end
                end
                ADCDC_HOST_SHIFT: begin
                    div_reg <= div_hit ? 8'h00 : div_reg + 8'h01;
                    if (div_hit) begin
                        if (sclk_reg) begin
                            // Sample the line just before each falling edge
                            data_reg  <= {data_reg[TOT_BITS-2:0], sdo_new};
                            sclk_reg  <= 1'b0;
                            edges_reg <= edges_reg + 16'h0001;
                            if (edges_reg + 16'h0001 == edges_need) begin
                                cnt_reg   <= 16'(ADCDC_GAP_CYC);
                                state_reg <= ADCDC_HOST_GAP;
                            end
                        end else begin
                            sclk_reg <= 1'b1;
                        end
                    end
                end
                ADCDC_HOST_GAP: begin
                    // Strobe stays high through the quiet gap after all bits are in
                    cnt_reg <= cnt_reg - 16'h0001;
                    if (cnt_reg == 16'h0000) begin
                        strobe_reg <= 1'b0;
                        state_reg  <= ADCDC_HOST_DONE;
                    end
                end
                ADCDC_HOST_DONE: begin
                    state_reg <= ADCDC_HOST_IDLE;
                end
                default: state_reg <= ADCDC_HOST_IDLE;
            endcase
        end
    end

    assign link.conversion_start_strobe = strobe_reg;
    assign link.shift_clk               = sclk_reg;
    assign ready      = (state_reg == ADCDC_HOST_IDLE);
    assign done       = (state_reg == ADCDC_HOST_DONE);
    assign chain_data = data_reg;

endmodule
`default_nettype wire

//--- adcdc_link_props.sv
/* Checker for the host-side link of the converter chain.
   Assumes one mclk domain; instantiated beside the link it watches. */
`timescale 1ns/1ps
`default_nettype none
module adcdc_link_props
    import adcdc_pkg::*;
#(
    parameter int unsigned CHAIN_LEN = 2
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic conversion_start_strobe,
    input wire logic shift_clk,
    input wire logic serial_chain_input,
    input wire logic serial_chain_output
);
    localparam int unsigned BITS = ADCDC_WORD_BITS * CHAIN_LEN;
    localparam int unsigned SPAN = ADCDC_CONV_CYC + BITS * 2 * ADCDC_SCLK_HALF;
    localparam int CONV_LO = 56;
    localparam int CONV_HI = 80;
    logic        sclk_d_reg;
    logic        stb_d_reg;
    logic        busy_reg;
    int unsigned cyc_reg;
    int unsigned edges_reg;
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    // Edge finders on the link lines
    wire fall_w = sclk_d_reg & ~shift_clk;
    wire rise_w = ~stb_d_reg & conversion_start_strobe;
    // Cycles and falling edges since strobe rise
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sclk_d_reg <= 1'b0;
            stb_d_reg  <= 1'b0;
            busy_reg   <= 1'b0;
            cyc_reg    <= 0;
            edges_reg  <= 0;
        end else begin
            sclk_d_reg <= shift_clk;
            stb_d_reg  <= conversion_start_strobe;
            busy_reg   <= rise_w ? shift_clk : busy_reg;
            cyc_reg    <= rise_w ? 0 : cyc_reg + 1;
            edges_reg  <= rise_w ? 0 : edges_reg + (conversion_start_strobe & fall_w);
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_select_low;
        ##8 !serial_chain_output [*8];
    endsequence
    sequence s_busy_out;
        ##[CONV_LO:CONV_HI] serial_chain_output;
    endsequence
    property p_strobe_span;
        $fell(conversion_start_strobe) |-> cyc_reg >= SPAN;
    endproperty
    property p_edge_count;
        $fell(conversion_start_strobe) |-> edges_reg == BITS + busy_reg;
    endproperty
    property p_quiet_conv;
        fall_w && conversion_start_strobe && edges_reg == 0 |-> cyc_reg >= ADCDC_CONV_CYC;
    endproperty
    property p_level_hold;
        rise_w |=> $stable(shift_clk) [*8];
    endproperty
    property p_low_select;
        rise_w && !shift_clk |-> s_select_low;
    endproperty
    property p_busy_bit;
        rise_w && shift_clk |-> s_busy_out;
    endproperty
    property p_zero_fill;
        conversion_start_strobe && !rise_w && !busy_reg && edges_reg >= 17
            |-> !serial_chain_input;
    endproperty
    property p_one_fill;
        conversion_start_strobe && !rise_w && busy_reg && edges_reg >= 18
            |-> serial_chain_input;
    endproperty
    a_strobe_span: assert property (p_strobe_span) else $error("strobe dropped early");
    a_edge_count: assert property (p_edge_count) else $error("wrong edge count");
    a_quiet_conv: assert property (p_quiet_conv) else $error("shift edge in conversion");
    a_level_hold: assert property (p_level_hold) else $error("shift level moved");
    a_low_select: assert property (p_low_select) else $error("output not low");
    a_busy_bit: assert property (p_busy_bit) else $error("no busy bit");
    a_zero_fill: assert property (p_zero_fill) else $error("first end not low");
    a_one_fill: assert property (p_one_fill) else $error("first end not high");
endmodule
`default_nettype wire

//--- adc_daisy_chain_readout_tb_top.sv
/* Bench: host end driving a chain of two converter ends.
   Assumes default host parameters and the package timing constants. */
`timescale 1ns/1ps
`default_nettype none
module adc_daisy_chain_readout_tb_top;
    import adcdc_pkg::*;
    localparam logic [15:0] CODES [4] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000};
    logic        mclk;
    logic        sys_rst;
    logic        start;
    logic        want_busy;
    logic [1:0]  sdi_sel;
    logic [15:0] code_a;
    logic [15:0] code_b;
    logic        ready;
    logic        done;
    logic [32:0] chain_data;
    logic [3:0]  dev_a;
    logic [3:0]  dev_b;
    int          fails;
    int          checked;
    int          takes;
    adcdc_link_if link_a ();
    adcdc_link_if link_b ();
    // ------------------------------------------------------------
    // Chain wiring
    // ------------------------------------------------------------
    // First end input: ground, strobe or high
    assign link_a.conversion_start_strobe = link_b.conversion_start_strobe;
    assign link_a.shift_clk = link_b.shift_clk;
    assign link_a.serial_chain_input = (sdi_sel == 2'h0) ? 1'b0 :
        (sdi_sel == 2'h1) ? link_b.conversion_start_strobe : 1'b1;
    assign link_b.serial_chain_input = link_a.serial_chain_output;
    adcdc_device adcdc_device_inst (.mclk(mclk), .sys_rst(sys_rst), .link(link_a),
        .sample_code(code_a), .sample_taken(dev_a[3]), .powered_up(dev_a[2]),
        .chain_mode(dev_a[1]), .busy_mode(dev_a[0]));
    adcdc_device adcdc_device_inst2 (.mclk(mclk), .sys_rst(sys_rst), .link(link_b),
        .sample_code(code_b), .sample_taken(dev_b[3]), .powered_up(dev_b[2]),
        .chain_mode(dev_b[1]), .busy_mode(dev_b[0]));
    adcdc_host adcdc_host_inst (.mclk(mclk), .sys_rst(sys_rst), .link(link_b),
        .start(start), .want_busy(want_busy), .ready(ready), .done(done),
        .chain_data(chain_data));
    adcdc_link_props #(.CHAIN_LEN(2)) adcdc_link_props_inst (.mclk(mclk),
        .sys_rst(sys_rst), .conversion_start_strobe(link_b.conversion_start_strobe),
        .shift_clk(link_b.shift_clk), .serial_chain_input(link_b.serial_chain_input),
        .serial_chain_output(link_b.serial_chain_output));
    // System clock
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;
    // Accepted strobe edges of both ends
    always @(posedge mclk) begin
        if (sys_rst) begin
            takes <= 0;
        end else begin
            takes <= takes + dev_a[3] + dev_b[3];
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Bound ran out: count it and close
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            fails++;
            give_verdict();
        end
    endtask
    // One frame: start, look in mid-conversion, collect at done
    task automatic frame(input logic busy, input logic [15:0] a, input logic [15:0] b);
        int  n;
        int  t0;
        logic sel;
        sel = (sdi_sel != 2'h2);
        t0 = takes;
        check(ready, 1'b1);
        want_busy = busy;
        code_a = a;
        code_b = b;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        n = 0;
        while (dev_b[2] !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        bound(n, 50);
        check(dev_b[1:0], {1'b1, busy});
        check(dev_a[2:1], {sel, sel});
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        bound(n, 2000);
        check({dev_a[2], dev_b[2]}, 2'h0);
        check(33'(takes - t0), 33'(sel + 1));
        if (!sel) begin
            check(chain_data[31:16], b);
        end else begin
            check(chain_data[31:0], {b, a});
            check(chain_data[32], busy);
            check(link_a.serial_chain_output, busy);
        end
        $display("frame done busy=%0d sel=%0d", busy, sdi_sel);
        @(negedge mclk);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        start = 1'b0;
        want_busy = 1'b0;
        sdi_sel = 2'h0;
        code_a = 16'h0000;
        code_b = 16'h0000;
        fails = 0;
        checked = 0;
        repeat (6) @(negedge mclk);
        check({dev_a, dev_b, done}, 9'h000);
        sys_rst = 1'b0;
        @(negedge mclk);
        $display("reset test done");
        // Code table ends and midscale codes, back to back
        for (int i = 0; i < 4; i++) begin
            frame(1'b0, CODES[i], ~CODES[i]);
        end
        // First end refuses with input high
        sdi_sel = 2'h2;
        frame(1'b0, 16'h1234, 16'h8000);
        // Busy option with input tied to strobe
        sdi_sel = 2'h1;
        frame(1'b1, 16'hFFFF, 16'h8000);
        give_verdict();
    end
endmodule
`default_nettype wire
